/* common/qspi_poll_pkg.sv */
package qspi_poll_pkg;
  // Register byte offsets.
  localparam logic [7:0] OFS_SIG_EN = 8'h00;
  localparam logic [7:0] OFS_TAP    = 8'h04;
  localparam logic [7:0] OFS_STAT   = 8'h08;
  localparam logic [7:0] OFS_POLL   = 8'h0c;
  localparam logic [7:0] OFS_THR    = 8'h10;
  localparam logic [2:0] SIZE_WORD  = 3'h2;
  // Interrupt signal enable layout.
  localparam int         SIG_EN_W   = 12;
  localparam int         EV_DMA_LSB = 9;
  localparam int         EV_CTHR    = 8;
  localparam int         EV_BUF_W   = 8;
  // Tap control layout.
  localparam int         CLKIN_LSB  = 8;
  localparam int         CLKIN_W    = 6;
  localparam int         DOUT_LSB   = 4;
  localparam int         COUT_LSB   = 0;
  localparam int         TAP4_W     = 4;
  // Flash status poll configuration layout.
  localparam int         OPC_LSB    = 0;
  localparam int         SDATA_LSB  = 8;
  localparam int         BYTES_LSB  = 16;
  localparam int         LANE_LSB   = 18;
  localparam int         POS_BIT    = 20;
  // Poll control and threshold layout.
  localparam int         POLL_GO    = 0;
  localparam int         POLL_ACT   = 0;
  localparam int         POLL_RDY   = 1;
  localparam int         THR_W      = 5;
  localparam logic [1:0] LANE_SINGLE = 2'h0;
  localparam logic [1:0] LANE_DUAL   = 2'h1;
  localparam logic [1:0] LANE_QUAD   = 2'h2;
  localparam logic [1:0] BYTES_ONE   = 2'h1;
  localparam logic [1:0] BYTES_TWO   = 2'h2;
  localparam logic [2:0] BUSY_HI_BIT = 3'h7;
  localparam logic [2:0] BUSY_LO_BIT = 3'h0;
  localparam logic [4:0] CMD_BITS    = 5'h08;
  localparam logic [4:0] RD1_BITS    = 5'h08;
  localparam logic [4:0] RD2_BITS    = 5'h10;
  // Chip select high time between two polls.
  localparam int         CLK_PERIOD_NS = 5;
  localparam int         CS_HIGH_NS    = 50;
  localparam int         CS_GAP_CYC    = (CS_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] CS_GAP_LAST   = 4'(CS_GAP_CYC - 1);
  typedef enum logic [3:0] {
    P_IDLE = 4'b0001,
    P_CMD  = 4'b0010,
    P_READ = 4'b0100,
    P_GAP  = 4'b1000
  } poll_state_e;
endpackage : qspi_poll_pkg

/* common/poll_if.sv */
`timescale 1ns/10ps
interface poll_if;
  logic       start;
  logic [7:0] opcode;
  logic [1:0] lane;
  logic [1:0] nbytes;
  logic       busy_pos;
  logic       active;
  logic       done;
  logic       upd;
  logic [7:0] status;
  logic       sck;
  logic       cs_n;
  logic [3:0] dq_out;
  logic [3:0] dq_oe;
  logic [3:0] dq_in;
  modport ctrl (output start, opcode, lane, nbytes, busy_pos, dq_in,
                input active, done, upd, status, sck, cs_n, dq_out, dq_oe);
  modport eng  (input start, opcode, lane, nbytes, busy_pos, dq_in,
                output active, done, upd, status, sck, cs_n, dq_out, dq_oe);
endinterface : poll_if

/* design/flash_status_poller.sv */
`timescale 1ns/10ps
module flash_status_poller
  import qspi_poll_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  poll_if.eng      pif
);
  typedef struct packed {
    poll_state_e st;
    logic        sck_hi;
    logic        again;
    logic [4:0]  cnt;
    logic [7:0]  tx;
    logic [15:0] rx;
    logic [3:0]  gap;
    logic        sck;
    logic        cs_n;
    logic [3:0]  dq_out;
    logic [3:0]  dq_oe;
    logic        done;
    logic        upd;
    logic [7:0]  status;
  } eng_s;

  eng_s       r;
  eng_s       n;
  logic [1:0] sh;
  logic [7:0] cap;

  function automatic logic [3:0] lane_bits(input logic [7:0] v, input logic [1:0] s);
    case (s)
      2'h0:    lane_bits = {3'h0, v[7]};
      2'h1:    lane_bits = {2'h0, v[7:6]};
      default: lane_bits = v[7:4];
    endcase
  endfunction : lane_bits

  always_comb begin
    n = r;
    n.done = 1'b0;
    n.upd = 1'b0;
    cap = 8'h00;
    case (pif.lane)
      LANE_DUAL: sh = 2'h1;
      LANE_QUAD: sh = 2'h2;
      default:   sh = 2'h0;
    endcase
    case (r.st)
      P_IDLE: begin
        if (pif.start || r.again) begin
          n.st = P_CMD;
          n.again = 1'b0;
          n.cs_n = 1'b0;
          n.sck_hi = 1'b0;
          n.tx = pif.opcode;
          n.cnt = CMD_BITS >> sh;
          n.dq_out = lane_bits(pif.opcode, sh);
          n.dq_oe = (sh == 2'h0) ? 4'h1 : ((sh == 2'h1) ? 4'h3 : 4'hf);
        end
      end
      P_CMD: begin
        n.sck_hi = ~r.sck_hi;
        n.sck = ~r.sck_hi;
        if (r.sck_hi) begin
          n.tx = r.tx << (4'h1 << sh);
          n.dq_out = lane_bits(n.tx, sh);
          n.cnt = r.cnt - 5'h01;
          if (r.cnt == 5'h01) begin
            n.st = P_READ;
            n.cnt = ((pif.nbytes == BYTES_TWO) ? RD2_BITS : RD1_BITS) >> sh;
            n.dq_oe = 4'h0;
            n.dq_out = 4'h0;
          end
        end
      end
      P_READ: begin
        n.sck_hi = ~r.sck_hi;
        n.sck = ~r.sck_hi;
        if (r.sck_hi) begin
          case (sh)
            2'h0:    n.rx = {r.rx[14:0], pif.dq_in[1]};
            2'h1:    n.rx = {r.rx[13:0], pif.dq_in[1:0]};
            default: n.rx = {r.rx[11:0], pif.dq_in};
          endcase
          n.cnt = r.cnt - 5'h01;
          if (r.cnt == 5'h01) begin
            cap = (pif.nbytes == BYTES_TWO) ? n.rx[15:8] : n.rx[7:0];
            n.status = cap;
            n.upd = 1'b1;
            n.cs_n = 1'b1;
            if (cap[pif.busy_pos ? BUSY_HI_BIT : BUSY_LO_BIT]) begin
              n.st = P_GAP;
              n.gap = CS_GAP_LAST;
            end else begin
              n.st = P_IDLE;
              n.done = 1'b1;
            end
          end
        end
      end
      P_GAP: begin
        n.gap = r.gap - 4'h1;
        if (r.gap == 4'h0) begin
          n.st = P_IDLE;
          n.again = 1'b1;
        end
      end
      default: n.st = P_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '{st: P_IDLE, cs_n: 1'b1, default: '0};
    end else begin
      r <= n;
    end
  end

  assign pif.active = (r.st != P_IDLE) || r.again;
  assign pif.done   = r.done;
  assign pif.upd    = r.upd;
  assign pif.status = r.status;
  assign pif.sck    = r.sck;
  assign pif.cs_n   = r.cs_n;
  assign pif.dq_out = r.dq_out;
  assign pif.dq_oe  = r.dq_oe;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_BUSY_RETRY: assert property (r.upd && r.status[7] && pif.busy_pos |-> r.st == P_GAP)
    else $error("Busy bit 7 did not start a retry.");
  AST_QUAD_OE: assert property ($rose(!r.cs_n) && pif.lane == LANE_QUAD |-> r.dq_oe == 4'hf)
    else $error("Quad command does not drive four lanes.");
  AST_RETRY_BOUND: assert property (r.st == P_GAP |-> ##[1:12] r.st == P_CMD)
    else $error("Retry did not restart the status command.");
  COV_POLL_DONE: cover property (r.done);
  COV_RETRY: cover property (r.st == P_GAP ##[1:40] r.done);
endmodule : flash_status_poller

/* design/qspi_irq_tap_status_cfg.sv */
`timescale 1ns/10ps
// Behaviour
// - Enable bit 11 gates the DMA bus error event onto the interrupt.
// - Enable bit 10 gates the packet-done event onto the interrupt.
// - Enable bit 9 gates the descriptor-done event onto the interrupt.
// - Control buffer enables: threshold bit 8, empty bit 7, full bit 6.
// - Receive buffer enables: threshold bit 5, full bit 4, empty bit 3.
// - Enables are active high, reset to zero, bits 31 to 12 read zero.
// - Sample clock delay is the 6-bit field plus one taps.
// - Outgoing data delay is the 4-bit field plus one taps.
// - Outgoing clock delay is the 4-bit field plus one taps.
// - Busy bit is status bit 7 when the position select is one, else bit 0.
// - Status command lane mode: 00 single, 01 dual, 10 quad, 11 reserved.
// - Status read is one byte for 01, two bytes for 10.
// - Captured flash status sits in bits 15 to 8 of the poll config.
// - Tap control bits 31 to 14 read as zero.
// - Poll config bits 31 to 21 read as zero; fields reset to zero.
// - Control threshold event rises when free space reaches the threshold.
module qspi_irq_tap_status_cfg
  import qspi_poll_pkg::*;
(
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  input  wire logic [2:0]           dma_events,
  input  wire logic [EV_BUF_W-1:0]  buf_events,
  input  wire logic [THR_W-1:0]     ctrl_buf_free,
  output logic                      irq,
  output logic      [CLKIN_W:0]     sample_clock_taps,
  output logic      [TAP4_W:0]      outgoing_data_taps,
  output logic      [TAP4_W:0]      outgoing_clock_taps,
  output logic                      flash_sck,
  output logic                      flash_cs_n,
  output logic      [3:0]           flash_dq_out,
  output logic      [3:0]           flash_dq_oe,
  input  wire logic [3:0]           flash_dq_in
);
  typedef struct packed {
    logic [SIG_EN_W-1:0] sig_en;
    logic [CLKIN_W-1:0]  clkin_dly;
    logic [TAP4_W-1:0]   dout_dly;
    logic [TAP4_W-1:0]   cout_dly;
    logic                busy_pos;
    logic [1:0]          lane;
    logic [1:0]          nbytes;
    logic [7:0]          stat_data;
    logic [7:0]          opcode;
    logic [THR_W-1:0]    thresh;
    logic                ready;
    logic                start;
    logic                dp_wr;
    logic                dp_rd;
    logic [7:0]          dp_addr;
    logic [31:0]         hrdata;
    logic                hreadyout;
    logic                hresp;
    logic                thr_evt;
    logic                irq;
    logic [CLKIN_W:0]    in_taps;
    logic [TAP4_W:0]     dout_taps;
    logic [TAP4_W:0]     cout_taps;
  } cfg_state_s;

  cfg_state_s          r;
  cfg_state_s          n;
  logic                acc;
  logic [SIG_EN_W-1:0] flags;
  logic [SIG_EN_W-1:0] gated;

  poll_if pif ();

  flash_status_poller u_poller (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pif     (pif)
  );

  assign pif.start    = r.start;
  assign pif.opcode   = r.opcode;
  assign pif.lane     = r.lane;
  assign pif.nbytes   = r.nbytes;
  assign pif.busy_pos = r.busy_pos;
  assign pif.dq_in    = flash_dq_in;

  assign flags = {dma_events, r.thr_evt, buf_events};

  genvar g;
  generate
    for (g = 0; g < SIG_EN_W; g++) begin : g_gate
      assign gated[g] = flags[g] & r.sig_en[g];
    end
  endgenerate

  function automatic logic [31:0] rd_word(input logic [7:0] a, input cfg_state_s s,
                                          input logic act);
    rd_word = 32'h0000_0000;
    case (a)
      OFS_SIG_EN: rd_word[SIG_EN_W-1:0] = s.sig_en;
      OFS_TAP: begin
        rd_word[CLKIN_LSB +: CLKIN_W] = s.clkin_dly;
        rd_word[DOUT_LSB +: TAP4_W] = s.dout_dly;
        rd_word[COUT_LSB +: TAP4_W] = s.cout_dly;
      end
      OFS_STAT: begin
        rd_word[POS_BIT] = s.busy_pos;
        rd_word[LANE_LSB +: 2] = s.lane;
        rd_word[BYTES_LSB +: 2] = s.nbytes;
        rd_word[SDATA_LSB +: 8] = s.stat_data;
        rd_word[OPC_LSB +: 8] = s.opcode;
      end
      OFS_POLL: begin
        rd_word[POLL_ACT] = act;
        rd_word[POLL_RDY] = s.ready;
      end
      OFS_THR: rd_word[THR_W-1:0] = s.thresh;
      default: rd_word = 32'h0000_0000;
    endcase
  endfunction : rd_word

  always_comb begin
    n = r;
    n.start = 1'b0;
    // Reads take one wait state so that read data always leave a flip-flop.
    acc = hsel && htrans[1] && hready;
    n.dp_wr = acc && hwrite && (hsize == SIZE_WORD);
    n.dp_rd = acc && !hwrite;
    n.dp_addr = acc ? haddr[7:0] : r.dp_addr;
    n.hreadyout = !(acc && !hwrite);
    n.hresp = 1'b0;
    if (r.dp_rd) begin
      // The start and done cycles read as busy, so ready is never seen stale.
      n.hrdata = rd_word(r.dp_addr, r, pif.active || pif.done || r.start);
    end
    if (r.dp_wr) begin
      case (r.dp_addr)
        OFS_SIG_EN: n.sig_en = hwdata[SIG_EN_W-1:0];
        OFS_TAP: begin
          n.clkin_dly = hwdata[CLKIN_LSB +: CLKIN_W];
          n.dout_dly = hwdata[DOUT_LSB +: TAP4_W];
          n.cout_dly = hwdata[COUT_LSB +: TAP4_W];
        end
        OFS_STAT: begin
          n.busy_pos = hwdata[POS_BIT];
          n.lane = hwdata[LANE_LSB +: 2];
          n.nbytes = hwdata[BYTES_LSB +: 2];
          n.stat_data = hwdata[SDATA_LSB +: 8];
          n.opcode = hwdata[OPC_LSB +: 8];
        end
        OFS_POLL: begin
          if (hwdata[POLL_GO] && !pif.active && !pif.done) begin
            n.start = 1'b1;
            n.ready = 1'b0;
          end
        end
        OFS_THR: n.thresh = hwdata[THR_W-1:0];
        default: n = n;
      endcase
    end
    // poller result wins over a write.
    if (pif.upd) begin
      n.stat_data = pif.status;
    end
    if (pif.done) begin
      n.ready = 1'b1;
    end
    n.thr_evt = (ctrl_buf_free >= r.thresh);
    n.irq = |gated;
    n.in_taps = {1'b0, r.clkin_dly} + 7'h01;
    n.dout_taps = {1'b0, r.dout_dly} + 5'h01;
    n.cout_taps = {1'b0, r.cout_dly} + 5'h01;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '{hreadyout: 1'b1, in_taps: 7'h01, dout_taps: 5'h01, cout_taps: 5'h01,
             default: '0};
    end else begin
      r <= n;
    end
  end

  assign hrdata              = r.hrdata;
  assign hreadyout           = r.hreadyout;
  assign hresp               = r.hresp;
  assign irq                 = r.irq;
  assign sample_clock_taps   = r.in_taps;
  assign outgoing_data_taps  = r.dout_taps;
  assign outgoing_clock_taps = r.cout_taps;
  assign flash_sck           = pif.sck;
  assign flash_cs_n          = pif.cs_n;
  assign flash_dq_out        = pif.dq_out;
  assign flash_dq_oe         = pif.dq_oe;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_DMA_ERR: assert property (r.sig_en[11] && dma_events[2] |=> irq)
    else $error("Enabled DMA bus error did not raise the interrupt.");
  AST_PKT_DONE: assert property (r.sig_en[10] && dma_events[1] |=> irq)
    else $error("Enabled packet done did not raise the interrupt.");
  AST_BD_DONE: assert property (r.sig_en[9] && dma_events[0] |=> irq)
    else $error("Enabled descriptor done did not raise the interrupt.");
  AST_CTRL_EMPTY: assert property (r.sig_en[7] && buf_events[7] |=> irq)
    else $error("Enabled control empty did not raise the interrupt.");
  AST_RX_FULL: assert property (r.sig_en[4] && buf_events[4] |=> irq)
    else $error("Enabled receive full did not raise the interrupt.");
  AST_TX_EMPTY: assert property (r.sig_en[0] && buf_events[0] |=> irq)
    else $error("Enabled transmit empty did not raise the interrupt.");
  AST_EN_READ: assert property (r.dp_rd && r.dp_addr == OFS_SIG_EN |=>
      hrdata[31:12] == 20'h00000 && hrdata[11:0] == $past(r.sig_en) && hreadyout)
    else $error("Enable register read back wrong.");
  AST_IN_TAPS: assert property (r.dp_wr && r.dp_addr == OFS_TAP |-> ##2
      sample_clock_taps == {1'b0, $past(hwdata[13:8], 2)} + 7'h01)
    else $error("Sample clock taps not field plus one.");
  AST_OUT_TAPS: assert property (r.dp_wr && r.dp_addr == OFS_TAP |-> ##2
      outgoing_clock_taps == {1'b0, $past(hwdata[3:0], 2)} + 5'h01)
    else $error("Outgoing clock taps not field plus one.");
  AST_THRESH: assert property (ctrl_buf_free < r.thresh |=> !r.thr_evt)
    else $error("Threshold event without enough free space.");
  AST_IRQ_QUIET: assert property (!(|gated) |=> !irq)
    else $error("Interrupt raised with no enabled event.");
  COV_IRQ: cover property ($rose(irq));
  COV_READ: cover property (r.dp_rd ##1 hreadyout);
endmodule : qspi_irq_tap_status_cfg

/* sim/flash_status_model.sv */
`timescale 1ns/10ps
module flash_status_model (
  input  wire logic       sck,
  input  wire logic       cs_n,
  input  wire logic [3:0] dq,
  input  wire logic [1:0] lane,
  input  wire logic       clr,
  input  wire logic [7:0] busy_val,
  input  wire logic [7:0] ready_val,
  input  wire logic [7:0] n_busy,
  output logic      [3:0] dq_drv,
  output logic      [7:0] opcode,
  output int              frames,
  output int              groups
);
  int         w;
  int         g;
  logic [7:0] st;
  initial begin
    dq_drv = 4'h0;
    opcode = 8'h00;
    frames = 0;
    groups = 0;
    g      = 0;
  end
  always_comb w = (lane == 2'h1) ? 2 : (lane == 2'h2) ? 4 : 1;
  // A released line shows the inverse of its last value, so stale data never passes.
  always @(posedge cs_n or posedge clr) begin
    if (clr) begin
      frames = 0;
    end else begin
      frames = frames + 1;
      groups = g;
      dq_drv = ~dq_drv;
    end
  end
  always @(negedge cs_n) begin
    g      = 0;
    opcode = 8'h00;
  end
  always @(posedge sck) begin
    if (!cs_n) begin
      if (g < 8 / w) begin
        opcode = 8'((opcode << w) | (dq & 4'((1 << w) - 1)));
      end
      g = g + 1;
    end
  end
  always @(negedge sck) begin
    if (!cs_n && g >= 8 / w) begin
      st     = (frames < int'(n_busy)) ? busy_val : ready_val;
      st     = st >> (8 - w * ((g - 8 / w) % (8 / w) + 1));
      dq_drv = (w == 1) ? {2'b00, st[0], 1'b0} : 4'(st & 8'((1 << w) - 1));
    end
  end
endmodule : flash_status_model

/* sim/qspi_irq_tap_status_cfg_tb_top.sv */
`timescale 1ns/10ps
module qspi_irq_tap_status_cfg_tb_top
  import qspi_poll_pkg::*;
();
  logic                hclk;
  logic                hresetn;
  logic                hsel;
  logic [31:0]         haddr;
  logic [1:0]          htrans;
  logic                hwrite;
  logic [2:0]          hsize;
  logic [31:0]         hwdata;
  logic [31:0]         hrdata;
  logic                hreadyout;
  logic                hresp;
  logic [2:0]          dma_events;
  logic [EV_BUF_W-1:0] buf_events;
  logic [THR_W-1:0]    ctrl_buf_free;
  logic                irq;
  logic [CLKIN_W:0]    sample_clock_taps;
  logic [TAP4_W:0]     outgoing_data_taps;
  logic [TAP4_W:0]     outgoing_clock_taps;
  logic                flash_sck;
  logic                flash_cs_n;
  logic [3:0]          flash_dq_out;
  logic [3:0]          flash_dq_oe;
  logic [3:0]          dq_wire;
  logic [3:0]          dq_drv;
  logic [1:0]          lane_m;
  logic                clr;
  logic [7:0]          busy_m;
  logic [7:0]          ready_m;
  logic [7:0]          nbusy_m;
  logic [7:0]          opcode_m;
  int                  frames_m;
  int                  groups_m;
  int                  errors;
  int                  n_checks;
  logic [31:0]         r;
  logic [7:0]          ofs [5] = '{OFS_SIG_EN, OFS_TAP, OFS_STAT, OFS_THR, 8'h20};
  logic [31:0]         msk [5] = '{32'hfff, 32'h3fff, 32'h1fffff, 32'h1f, 32'h0};

  assign dq_wire = (flash_dq_oe & flash_dq_out) | (~flash_dq_oe & dq_drv);
  always #2.5 hclk = ~hclk;

  qspi_irq_tap_status_cfg uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .dma_events(dma_events),
    .buf_events(buf_events), .ctrl_buf_free(ctrl_buf_free), .irq(irq),
    .sample_clock_taps(sample_clock_taps), .outgoing_data_taps(outgoing_data_taps),
    .outgoing_clock_taps(outgoing_clock_taps), .flash_sck(flash_sck),
    .flash_cs_n(flash_cs_n), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
    .flash_dq_in(dq_wire));

  flash_status_model flash (
    .sck(flash_sck), .cs_n(flash_cs_n), .dq(dq_wire), .lane(lane_m), .clr(clr),
    .busy_val(busy_m), .ready_val(ready_m), .n_busy(nbusy_m), .dq_drv(dq_drv),
    .opcode(opcode_m), .frames(frames_m), .groups(groups_m));

  task automatic conclude;
    if (errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] act);
    n_checks++;
    if (act !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, act);
    end
  endtask : chk

  // A slave that never answers must not hang the run.
  task automatic wait_rdy;
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (hreadyout !== 1'b1) begin
      errors++;
      conclude();
    end
  endtask : wait_rdy

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : ahb

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    ahb(1'b0, a, 32'h0, v);
    chk($sformatf("reg %h", a), exp, v);
  endtask : rdc

  task automatic set_ev(input logic [11:0] e);
    dma_events    <= e[11:9];
    buf_events    <= e[7:0];
    ctrl_buf_free <= e[8] ? 5'h05 : 5'h04;
  endtask : set_ev

  task automatic poll(input logic [1:0] ln, input logic [1:0] nb, input logic ps,
                      input logic [7:0] op, input logic [7:0] bv, input logic [7:0] rv,
                      input logic [7:0] nbusy);
    logic [31:0] cfg;
    logic [31:0] v;
    int          k;
    int          w;
    cfg     = {11'h0, ps, ln, nb, 8'h00, op};
    w       = (ln == 2'h1) ? 2 : (ln == 2'h2) ? 4 : 1;
    lane_m  <= ln;
    busy_m  <= bv;
    ready_m <= rv;
    nbusy_m <= nbusy;
    clr     <= 1'b1;
    ahb(1'b1, OFS_STAT, cfg, v);
    clr     <= 1'b0;
    ahb(1'b1, OFS_POLL, 32'h1, v);
    repeat (4) @(posedge hclk);
    k = 0;
    do begin
      ahb(1'b0, OFS_POLL, 32'h0, v);
      k++;
    end while (v[POLL_ACT] !== 1'b0 && k < 200);
    if (v[POLL_ACT] !== 1'b0) begin
      errors++;
      conclude();
    end
    chk("poll", 32'h2, v);
    rdc(OFS_STAT, cfg | {16'h0, rv, 8'h00});
    chk("opcode", {24'h0, op}, {24'h0, opcode_m});
    chk("frames", 32'(nbusy) + 32'h1, 32'(frames_m));
    chk("groups", 32'((8 + ((nb == 2'h2) ? 16 : 8)) / w), 32'(groups_m));
    chk("cs_n", 32'h1, {31'h0, flash_cs_n});
  endtask : poll

  initial begin
    hclk          = 1'b0;
    hresetn       = 1'b0;
    hsel          = 1'b0;
    haddr         = 32'h0;
    htrans        = 2'h0;
    hwrite        = 1'b0;
    hsize         = SIZE_WORD;
    hwdata        = 32'h0;
    dma_events    = 3'h0;
    buf_events    = 8'h00;
    ctrl_buf_free = 5'h00;
    lane_m        = 2'h0;
    clr           = 1'b0;
    busy_m        = 8'h00;
    ready_m       = 8'h00;
    nbusy_m       = 8'h00;
    errors        = 0;
    n_checks      = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    chk("taps", 32'h0421, 32'({sample_clock_taps, outgoing_data_taps, outgoing_clock_taps}));
    for (int i = 0; i < 5; i++) begin
      rdc(ofs[i], 32'h0);
      ahb(1'b1, ofs[i], 32'hffffffff, r);
      rdc(ofs[i], msk[i]);
    end
    chk("taps", 32'h10210, 32'({sample_clock_taps, outgoing_data_taps, outgoing_clock_taps}));
    ahb(1'b1, OFS_TAP, 32'h1a5c, r);
    rdc(OFS_TAP, 32'h1a5c);
    chk("taps", 32'h6ccd, 32'({sample_clock_taps, outgoing_data_taps, outgoing_clock_taps}));
    ahb(1'b1, OFS_THR, 32'h5, r);
    // Each enable alone must pass its own event and block all the others.
    for (int i = 0; i < 12; i++) begin
      ahb(1'b1, OFS_SIG_EN, 32'h1 << i, r);
      set_ev(~(12'h1 << i));
      repeat (3) @(posedge hclk);
      chk($sformatf("irq off %0d", i), 32'h0, {31'h0, irq});
      set_ev(12'h1 << i);
      repeat (3) @(posedge hclk);
      chk($sformatf("irq on %0d", i), 32'h1, {31'h0, irq});
    end
    ahb(1'b1, OFS_SIG_EN, 32'h0, r);
    set_ev(12'hfff);
    repeat (3) @(posedge hclk);
    chk("irq none", 32'h0, {31'h0, irq});
    set_ev(12'h000);
    poll(2'h0, 2'h1, 1'b1, 8'h05, 8'h81, 8'h01, 8'h01);
    poll(2'h1, 2'h2, 1'b0, 8'h3b, 8'h7f, 8'h80, 8'h02);
    poll(2'h2, 2'h1, 1'b1, 8'hc6, 8'hff, 8'h7e, 8'h00);
    poll(2'h3, 2'h0, 1'b0, 8'ha9, 8'ha5, 8'h5a, 8'h01);
    conclude();
  end
endmodule : qspi_irq_tap_status_cfg_tb_top
